// ===== verilog/pwm_update_pkg.sv
// Constants shared by the channel value update block: register map, fields and reset values.
package pwm_update_pkg;
	localparam logic [7:0]  OFS_STATUS_CONTROL = 8'h00;
	localparam logic [7:0]  OFS_MODULO_LOW     = 8'h04;
	localparam logic [7:0]  OFS_MODULO_HIGH    = 8'h08;
	localparam logic [7:0]  OFS_COMPARE_LOW    = 8'h0C;
	localparam logic [7:0]  OFS_COMPARE_HIGH   = 8'h10;
	localparam logic [7:0]  OFS_COUNTER        = 8'h14;
	localparam logic [7:0]  OFS_STATE          = 8'h18;
	localparam int          POS_CLOCK_SOURCE   = 0;
	localparam int          POS_CENTER_ALIGNED = 2;
	localparam int          POS_ACTIVE_LOW     = 3;
	localparam int          POS_ST_DEBUG       = 0;
	localparam int          POS_ST_OUTPUT      = 1;
	localparam int          POS_ST_COUNT_UP    = 2;
	localparam int          POS_ST_PENDING     = 3;
	localparam logic [1:0]  RESET_CLOCK_SOURCE = 2'h0;
	localparam logic [15:0] RESET_MODULO       = 16'h0000;
	localparam logic [15:0] RESET_COMPARE      = 16'h0000;
	localparam logic [15:0] FREE_RUN_TOP       = 16'hFFFF;
	localparam logic [15:0] FREE_RUN_ALT       = 16'h0000;
	localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
endpackage : pwm_update_pkg

// ===== verilog/pwm_channel_value_update.sv
// Timer counter with buffered channel compare value and edge or center-aligned output.
//
// Function
// - Edge mode, clock on: load buffered value after both bytes, at modulo-1 to modulo.
// - Center mode, clock on: load buffered value after both bytes, at modulo-1 to modulo.
// - Free-running counter: load at counter step from FFFE to FFFF.
// - Center mode: compare value equal to modulo gives full duty.
// - Center mode: compare value of modulo minus one gives nearly full duty.
// - Center mode: change from zero takes effect only at a new period.
// - Center mode: change to zero finishes current period with old duty.
// - In debug, a status/control write clears partial modulo byte state.
// - Center mode counts up to modulo, then down to zero, repeating.
// - Center mode: active on down-count match, inactive on up-count match.
// - Edge mode period is modulo plus one ticks; compare sets the transition.
// - Modulo of 0000 or FFFF makes the counter free-running over 16 bits.
`timescale 1ns/1ns
module pwm_channel_value_update
	import pwm_update_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        nrst,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Processor state and channel pin.
	input  wire logic        background_debug_state,
	output logic             channel_out
);
	logic [1:0]  counter_clock_source_select;
	logic        center_aligned;
	logic        active_low;
	logic [15:0] counter_modulo_value;
	logic [15:0] modulo_buffer;
	logic [1:0]  modulo_seen;
	logic [15:0] channel_compare_value;
	logic [15:0] compare_buffer;
	logic [1:0]  compare_seen;
	logic        compare_pending;
	logic [15:0] count;
	logic        count_up;
	logic        pwm_active;
	logic        dp_write;
	logic [7:0]  dp_addr;
	logic        addr_taken;
	logic        running;
	logic        tick;
	logic        free_run;
	logic [15:0] limit;
	logic        at_top;
	logic        load_compare;
	logic        compare_done;
	logic        wr_ctrl;
	logic        wr_mod_lo;
	logic        wr_mod_hi;
	logic        wr_cmp_lo;
	logic        wr_cmp_hi;
	logic [31:0] next_rdata;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_taken = hsel && hready && (htrans == HTRANS_NONSEQ);

	// Address phase is captured so the write lands in the following data phase.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else begin
			dp_write <= addr_taken && hwrite;
			dp_addr  <= haddr;
		end
	end

	assign wr_ctrl   = dp_write && (dp_addr == OFS_STATUS_CONTROL);
	assign wr_mod_lo = dp_write && (dp_addr == OFS_MODULO_LOW);
	assign wr_mod_hi = dp_write && (dp_addr == OFS_MODULO_HIGH);
	assign wr_cmp_lo = dp_write && (dp_addr == OFS_COMPARE_LOW);
	assign wr_cmp_hi = dp_write && (dp_addr == OFS_COMPARE_HIGH);

	// Byte registers read back the active value, never the half-written buffer,
	// so software always sees what the counter really compares against.
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (haddr)
			OFS_STATUS_CONTROL: begin
				next_rdata[POS_CLOCK_SOURCE +: 2] = counter_clock_source_select;
				next_rdata[POS_CENTER_ALIGNED]    = center_aligned;
				next_rdata[POS_ACTIVE_LOW]        = active_low;
			end
			OFS_MODULO_LOW:   next_rdata[7:0] = counter_modulo_value[7:0];
			OFS_MODULO_HIGH:  next_rdata[7:0] = counter_modulo_value[15:8];
			OFS_COMPARE_LOW:  next_rdata[7:0] = channel_compare_value[7:0];
			OFS_COMPARE_HIGH: next_rdata[7:0] = channel_compare_value[15:8];
			OFS_COUNTER:      next_rdata[15:0] = count;
			OFS_STATE: begin
				next_rdata[POS_ST_DEBUG]   = background_debug_state;
				next_rdata[POS_ST_OUTPUT]  = channel_out;
				next_rdata[POS_ST_COUNT_UP] = count_up;
				next_rdata[POS_ST_PENDING] = compare_pending;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data is registered at the address phase so it stands for the data phase.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_taken && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			counter_clock_source_select <= RESET_CLOCK_SOURCE;
			center_aligned              <= 1'b0;
			active_low                  <= 1'b0;
		end else if (wr_ctrl) begin
			counter_clock_source_select <= hwdata[POS_CLOCK_SOURCE +: 2];
			center_aligned              <= hwdata[POS_CENTER_ALIGNED];
			active_low                  <= hwdata[POS_ACTIVE_LOW];
		end
	end

	// Modulo takes effect once both bytes have been written, in either order.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			counter_modulo_value <= RESET_MODULO;
			modulo_buffer        <= RESET_MODULO;
			modulo_seen          <= 2'h0;
		end else begin
			if (wr_mod_lo) begin
				modulo_buffer[7:0] <= hwdata[7:0];
			end
			if (wr_mod_hi) begin
				modulo_buffer[15:8] <= hwdata[7:0];
			end
			if (wr_ctrl && background_debug_state) begin
				modulo_seen <= 2'h0;
			end else if ((modulo_seen | {wr_mod_hi, wr_mod_lo}) == 2'h3) begin
				modulo_seen          <= 2'h0;
				counter_modulo_value <= {wr_mod_hi ? hwdata[7:0] : modulo_buffer[15:8],
					wr_mod_lo ? hwdata[7:0] : modulo_buffer[7:0]};
			end else begin
				modulo_seen <= modulo_seen | {wr_mod_hi, wr_mod_lo};
			end
		end
	end

	assign running = (counter_clock_source_select != 2'h0);
	// Counting is suspended while the processor sits in debug.
	assign tick = running && !background_debug_state;
	assign free_run = (counter_modulo_value == FREE_RUN_ALT) ||
		(counter_modulo_value == FREE_RUN_TOP);
	assign limit = free_run ? FREE_RUN_TOP : counter_modulo_value;

	// Leaving center mode keeps the count where it stands, so the first edge-mode
	// period after a mode change may be short; stop the clock before switching.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count    <= 16'h0000;
			count_up <= 1'b1;
		end else if (tick) begin
			if (!center_aligned) begin
				count_up <= 1'b1;
				count    <= (count >= limit) ? 16'h0000 : count + 16'h0001;
			end else if (count_up) begin
				if (count >= limit) begin
					count_up <= 1'b0;
					count    <= count - 16'h0001;
				end else begin
					count <= count + 16'h0001;
				end
			end else if (count == 16'h0000) begin
				count_up <= 1'b1;
				count    <= 16'h0001;
			end else begin
				count <= count - 16'h0001;
			end
		end
	end

	assign at_top = count_up && (count == limit - 16'h0001);
	assign compare_done = (compare_seen | {wr_cmp_hi, wr_cmp_lo}) == 2'h3;
	assign load_compare = compare_pending && (!running || (tick && at_top));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			compare_buffer        <= RESET_COMPARE;
			compare_seen          <= 2'h0;
			compare_pending       <= 1'b0;
			channel_compare_value <= RESET_COMPARE;
		end else begin
			if (wr_cmp_lo) begin
				compare_buffer[7:0] <= hwdata[7:0];
			end
			if (wr_cmp_hi) begin
				compare_buffer[15:8] <= hwdata[7:0];
			end
			compare_seen <= compare_done ? 2'h0 : (compare_seen | {wr_cmp_hi, wr_cmp_lo});
			// A completed write wins over a load in the same cycle.
			if (compare_done) begin
				compare_pending <= 1'b1;
			end else if (load_compare) begin
				compare_pending <= 1'b0;
			end
			if (load_compare) begin
				channel_compare_value <= compare_buffer;
			end
		end
	end

	always_comb begin
		if (center_aligned) begin
			pwm_active = (channel_compare_value >= limit) || (count < channel_compare_value);
		end else begin
			pwm_active = (count < channel_compare_value);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			channel_out <= 1'b0;
		end else begin
			channel_out <= pwm_active ^ active_low;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Each load check compares against the buffer as it stood when the load fired,
	// so a byte write landing in that same cycle cannot mask a missed transfer.
	a_edge_top_load: assert property (compare_pending && tick && at_top && !center_aligned
		|=> channel_compare_value == $past(compare_buffer)) else $error("edge load missed");
	a_center_top_load: assert property (compare_pending && tick && at_top && center_aligned
		|=> channel_compare_value == $past(compare_buffer)) else $error("center load missed");
	a_hold_off_top: assert property (running && !(tick && at_top)
		|=> channel_compare_value == $past(channel_compare_value)) else $error("early load");
	a_free_load_step: assert property (free_run && tick && count_up && count == 16'hFFFE
		&& compare_pending |=> count == 16'hFFFF && channel_compare_value == $past(compare_buffer))
		else $error("free-run load wrong");
	a_full_duty: assert property (center_aligned && !active_low
		&& channel_compare_value == limit |=> channel_out) else $error("full duty lost");
	a_near_full: assert property (center_aligned && !active_low && !count_up
		&& count == 16'h0000 && channel_compare_value == limit - 16'h0001
		&& channel_compare_value != 16'h0000 && $stable(channel_compare_value)
		|=> channel_out) else $error("near full duty lost");
	a_debug_clear: assert property (wr_ctrl && background_debug_state
		|=> modulo_seen == 2'h0) else $error("modulo byte state kept");
	a_center_turn: assert property (center_aligned && tick && count_up && count == limit
		&& $stable(center_aligned) |=> !count_up && count == $past(limit) - 16'h0001)
		else $error("center turn wrong");
	a_center_bottom: assert property (center_aligned && tick && !count_up
		&& count == 16'h0000 |=> count_up && count == 16'h0001)
		else $error("center bottom turn wrong");
	a_edge_wrap: assert property (!center_aligned && tick && count == limit
		|=> count == 16'h0000) else $error("edge wrap wrong");
	a_stopped_load: assert property (!running && compare_pending
		|=> channel_compare_value == $past(compare_buffer)) else $error("stopped load missed");
	// A center-mode period is finished whole, whichever way the duty changes.
	a_zero_hold: assert property (center_aligned && running && !(tick && at_top)
		&& channel_compare_value == 16'h0000 |=> channel_compare_value == 16'h0000)
		else $error("zero duty left early");
	a_old_duty_kept: assert property (center_aligned && running && !(tick && at_top)
		&& channel_compare_value != 16'h0000 |=> channel_compare_value != 16'h0000)
		else $error("old duty dropped early");
	a_center_rise_off: assert property (center_aligned && !active_low && count_up
		&& count == channel_compare_value && channel_compare_value < limit
		|=> !channel_out) else $error("up-count match left output active");
	a_center_fall_on: assert property (center_aligned && !active_low && !count_up
		&& count < channel_compare_value && channel_compare_value < limit
		|=> channel_out) else $error("down-count match left output idle");

	// Covers show that every load path and the debug clear are really reached.
	c_edge_load: cover property (!center_aligned && load_compare && running);
	c_center_load: cover property (center_aligned && load_compare && running);
	c_debug_clear: cover property (wr_ctrl && background_debug_state && modulo_seen != 2'h0);
	c_stopped_load: cover property (!running && load_compare);
	c_free_load: cover property (free_run && load_compare && running);
endmodule : pwm_channel_value_update

// ===== verif/pwm_channel_value_update_test.sv
// Self-checking testbench for the channel value update block.
`timescale 1ns/1ns
module pwm_channel_value_update_test;
	import pwm_update_pkg::*;
	typedef struct packed { logic wr; logic [7:0] a; logic [31:0] d; } row_t;
	logic        clk;
	logic        nrst;
	logic        hsel;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        dbg;
	logic        chan;
	logic [31:0] rd_val;
	int          hi;
	int          err_total;
	int          n_checks;
	// Reads carry the expected value in d; writes carry the data.
	row_t rows [15] = '{
		{1'b0, 8'h00, 32'h0}, {1'b0, 8'h04, 32'h0}, {1'b0, 8'h08, 32'h0},
		{1'b0, 8'h0C, 32'h0}, {1'b0, 8'h10, 32'h0}, {1'b0, 8'h14, 32'h0},
		{1'b0, 8'h1C, 32'h0}, {1'b1, 8'h0C, 32'h5}, {1'b0, 8'h0C, 32'h0},
		{1'b1, 8'h10, 32'h0}, {1'b0, 8'h0C, 32'h5}, {1'b1, 8'h1C, 32'hFF},
		{1'b0, 8'h1C, 32'h0}, {1'b1, 8'h04, 32'h9}, {1'b1, 8'h08, 32'h0}};
	logic [31:0] cen [4][2] = '{'{32'h9, 32'h12}, '{32'h8, 32'hF}, '{32'h0, 32'h0},
		'{32'h4, 32'h7}};

	assign hready = hreadyout;

	pwm_channel_value_update uut (
		.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.background_debug_state(dbg), .channel_out(chan));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
			err_total++;
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd_val = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		bus(1'b1, a, {24'h0, v[7:0]});
		bus(1'b1, a + 8'h04, {24'h0, v[15:8]});
	endtask : wr16

	task automatic highs(input int n);
		hi = 0;
		repeat (n) begin
			@(negedge clk);
			if (chan === 1'b1) hi++;
		end
	endtask : highs

	task automatic set_dbg(input logic v);
		@(posedge clk);
		dbg <= v;
	endtask : set_dbg

	task automatic results;
		$display("checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		results();
	end

	initial begin
		nrst = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h0; dbg = 1'b0; err_total = 0; n_checks = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk(rd_val, rows[i].d);
		end
		$display("register table test done");
		bus(1'b1, OFS_STATUS_CONTROL, 32'h1);
		repeat (30) @(posedge clk);
		highs(20);
		chk(hi, 32'hA);
		// Freezing the counter makes the pending window deterministic.
		set_dbg(1'b1);
		wr16(OFS_COMPARE_LOW, 16'h0003);
		bus(1'b0, OFS_COMPARE_LOW, 32'h0);
		chk(rd_val, 32'h5);
		bus(1'b0, OFS_STATE, 32'h0);
		chk({31'h0, rd_val[POS_ST_PENDING]}, 32'h1);
		set_dbg(1'b0);
		repeat (30) @(posedge clk);
		bus(1'b0, OFS_COMPARE_LOW, 32'h0);
		chk(rd_val, 32'h3);
		highs(20);
		chk(hi, 32'h6);
		$display("edge aligned test done");
		set_dbg(1'b1);
		bus(1'b1, OFS_MODULO_LOW, 32'h2);
		bus(1'b1, OFS_STATUS_CONTROL, 32'h1);
		bus(1'b1, OFS_MODULO_HIGH, 32'h0);
		bus(1'b0, OFS_MODULO_LOW, 32'h0);
		chk(rd_val, 32'h9);
		bus(1'b1, OFS_MODULO_LOW, 32'h9);
		set_dbg(1'b0);
		$display("debug coherency test done");
		bus(1'b1, OFS_STATUS_CONTROL, 32'h5);
		for (int i = 0; i < 3; i++) begin
			wr16(OFS_COMPARE_LOW, cen[i][0][15:0]);
			repeat (40) @(posedge clk);
			highs(18);
			chk(hi, cen[i][1]);
		end
		set_dbg(1'b1);
		wr16(OFS_COMPARE_LOW, cen[3][0][15:0]);
		highs(8);
		chk(hi, 32'h0);
		bus(1'b0, OFS_COMPARE_LOW, 32'h0);
		chk(rd_val, 32'h0);
		set_dbg(1'b0);
		repeat (40) @(posedge clk);
		highs(18);
		chk(hi, cen[3][1]);
		$display("center aligned test done");
		bus(1'b1, OFS_STATUS_CONTROL, 32'h1);
		wr16(OFS_MODULO_LOW, 16'h0000);
		set_dbg(1'b1);
		wr16(OFS_COMPARE_LOW, 16'h1234);
		set_dbg(1'b0);
		repeat (65000) @(posedge clk);
		bus(1'b0, OFS_COMPARE_LOW, 32'h0);
		chk(rd_val, 32'h4);
		repeat (700) @(posedge clk);
		bus(1'b0, OFS_COMPARE_LOW, 32'h0);
		chk(rd_val, 32'h34);
		$display("free running test done");
		// A reset in mid-run must stop the counter and clear the output and the modulo value.
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		chk({31'h0, chan}, 32'h0);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		bus(1'b0, OFS_COUNTER, 32'h0);
		chk(rd_val, 32'h0);
		bus(1'b0, OFS_MODULO_LOW, 32'h0);
		chk(rd_val, 32'h0);
		wr16(OFS_COMPARE_LOW, 16'h0021);
		bus(1'b0, OFS_COMPARE_LOW, 32'h0);
		chk(rd_val, 32'h21);
		$display("reset test done");
		results();
	end
endmodule : pwm_channel_value_update_test
